// *** verilog/osptmr_top.sv ***
/*
 One-shot pulse timer with a period channel and three delay channels,
 APB register slave, external/software trigger, four output pins.
 Assumes one 40 MHz clock, asynchronous active-low reset and that
 the trigger and event pins are asynchronous.
*/
//
// Contract
// - Late trigger after period match restarts count
// - Ext mode early trigger suppresses period irq, restarts
// - Ext mode channel irq on match cycle
// - Mode 011 enters one-shot; run waits
// - Trigger moves FFFF to 0000, pulse starts
// - Pulse done: park FFFF, wait again
// - Triggers during pulse are ignored in one-shot mode
// - Channel asserts at its compare value
// - Channel active until period match inclusive
// - Period irq on count after match
// - Channel irq in match cycle
// - Trigger: pin edge or software bit
// - Channel 0 active while counting
// - Enable and level bit per channel
// - Edge select register, upper nibble zero
// - Counter readback returns live count
// - Compare writes reach shadows immediately
// - Lowered compares: wrap, then match
// - Capture edge and option regs ignored
`timescale 1ns/1ps
module osptmr_top
#(
   parameter int CNT_W = 16
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_pin,
   input wire logic event_pin,
   output osptmr_pkg::osptmr_out_t tmr_out
);
   initial
   begin
      if (CNT_W != 16)
         $error("osptmr_top supports a 16-bit counter only");
   end

   typedef enum logic [1:0] {
      OSPTMR_WAIT = 2'b01,
      OSPTMR_RUN = 2'b10
   } osptmr_state_t;

   osptmr_state_t state_reg;
   logic [7:0] ctl0_reg, ctl1_reg, ioc0_reg, ioc1_reg, ioc2_reg, opt0_reg;
   logic [15:0] ccr_reg [4];
   logic [15:0] cnt_reg;
   logic [6:0] pre_reg;
   logic trig_d_reg, evt_d_reg;
   logic [3:0] act_reg;
   logic trig_lvl, evt_lvl;

   osptmr_sync u_trig_sync
   (
      .clock(clock),
      .rst_n(rst_n),
      .pin(trigger_pin),
      .level(trig_lvl)
   );
   osptmr_sync u_evt_sync
   (
      .clock(clock),
      .rst_n(rst_n),
      .pin(event_pin),
      .level(evt_lvl)
   );

   // Bus decode
   wire acc_wr = psel && penable && pwrite;
   wire hit_ctl0 = paddr == osptmr_pkg::CTL0_OFF;
   wire hit_ctl1 = paddr == osptmr_pkg::CTL1_OFF;
   wire hit_ioc0 = paddr == osptmr_pkg::IOC0_OFF;
   wire hit_ioc1 = paddr == osptmr_pkg::IOC1_OFF;
   wire hit_ioc2 = paddr == osptmr_pkg::IOC2_OFF;
   wire hit_opt0 = paddr == osptmr_pkg::OPT0_OFF;
   wire hit_cnt = paddr == osptmr_pkg::CNT_OFF;
   wire hit_stat = paddr == osptmr_pkg::STAT_OFF;
   wire [3:0] hit_ccr = {paddr == osptmr_pkg::CCR3_OFF,
      paddr == osptmr_pkg::CCR2_OFF, paddr == osptmr_pkg::CCR1_OFF,
      paddr == osptmr_pkg::CCR0_OFF};
   wire hit_any = hit_ctl0 | hit_ctl1 | hit_ioc0 | hit_ioc1 | hit_ioc2
      | hit_opt0 | hit_cnt | hit_stat | (|hit_ccr);

   // Control fields
   wire run_bit = ctl0_reg[osptmr_pkg::CTL0_RUN_POS];
   wire [2:0] clk_sel = ctl0_reg[2:0];
   wire [2:0] mode = ctl1_reg[osptmr_pkg::CTL1_MD_LSB +: 3];
   wire one_shot = mode == osptmr_pkg::MODE_ONESHOT;
   wire ext_mode = mode == osptmr_pkg::MODE_EXTTRIG;
   wire active_mode = one_shot || ext_mode;

   // Shadows track registers directly, so writes take effect at once
   wire [15:0] per_cmp = ccr_reg[0];
   wire sw_trig = acc_wr && hit_ctl1
      && pwdata[osptmr_pkg::CTL1_SWTRG_POS];

   // Edge select: 00 none, 01 rising, 10 falling, 11 both
   wire [1:0] trg_es = ioc2_reg[1:0];
   wire [1:0] evt_es = ioc2_reg[3:2];
   wire trg_rise = trig_lvl && !trig_d_reg;
   wire trg_fall = !trig_lvl && trig_d_reg;
   wire ext_trig = (trg_es[0] && trg_rise) || (trg_es[1] && trg_fall);
   wire trig = ext_trig || sw_trig;
   wire evt_tick = (evt_es[0] && evt_lvl && !evt_d_reg)
      || (evt_es[1] && !evt_lvl && evt_d_reg);

   // Prescaler: fclk/2^sel for sel 0..6, external events for sel 7
   wire [6:0] pre_next = pre_reg + 7'h01;
   wire [7:0] pre_mask = 8'(8'h01 << clk_sel) - 8'h01;
   wire div_tick = ({1'b0, pre_reg} & pre_mask) == 8'(pre_mask);
   wire cnt_tick = (clk_sel == 3'h7) ? evt_tick : div_tick;

   wire running = state_reg == OSPTMR_RUN;
   wire tick_run = running && run_bit && cnt_tick;
   wire cnt_match0 = cnt_reg == per_cmp;
   wire [15:0] cnt_inc = cnt_reg + 16'h0001;

   // Pins and irqs follow the counter's next value, so they change
   // with the count itself despite the output flops.
   // A trigger after the period irq or in its cycle
   // restarts the count; only external mode does so.
   wire ext_retrig = ext_mode && running && run_bit && trig;
   wire stop_now = tick_run && cnt_match0 && one_shot;
   wire start = !running && trig && run_bit && active_mode;
   wire per_irq_now = tick_run && cnt_match0
      && !ext_retrig;

   logic [2:0] ch_irq;
   always_comb
   begin
      for (int k = 1; k < 4; k++)
         ch_irq[k-1] = (tick_run && !ext_retrig && !stop_now
            && cnt_inc == ccr_reg[k])
            || ((start || ext_retrig) && ccr_reg[k] == 16'h0000);
   end

   // Next counter value
   logic [15:0] cnt_next;
   always_comb
   begin
      cnt_next = cnt_reg;
      if (!run_bit || !active_mode)
         cnt_next = osptmr_pkg::CNT_PARK;
      else if (start || ext_retrig)
         cnt_next = osptmr_pkg::CNT_ZERO;
      else if (stop_now)
         cnt_next = osptmr_pkg::CNT_PARK;
      else if (running && cnt_tick)
         cnt_next = cnt_inc; // wraps through FFFF
   end

   // Channel activity: set at own compare, clear after period match
   logic [3:0] act_next;
   always_comb
   begin
      act_next = act_reg;
      act_next[0] = running;
      for (int k = 1; k < 4; k++)
      begin
         if (!running)
            act_next[k] = 1'b0;
         if (tick_run && cnt_match0)
            act_next[k] = 1'b0;
         if (tick_run && cnt_inc == ccr_reg[k])
            act_next[k] = 1'b1;
         if (ext_retrig && ccr_reg[k] == 16'h0000)
            act_next[k] = 1'b1;
      end
      if (!run_bit)
         act_next = 4'h0;
      if (start || ext_retrig)
      begin
         act_next[0] = 1'b1;
         for (int k = 1; k < 4; k++)
            act_next[k] = ccr_reg[k] == 16'h0000 || (ext_retrig && act_reg[k]);
      end
      if (stop_now)
         act_next = 4'h0;
   end

   // Pin levels: enable bit even, level bit odd
   logic [3:0] pin_next;
   always_comb
   begin
      // Disabled channel 0 drives its level bit
      pin_next[0] = ioc0_reg[0] ? act_next[0] : ioc0_reg[1];
      for (int k = 1; k < 4; k++)
         pin_next[k] = ioc0_reg[2*k] ? (act_next[k] ^ ioc0_reg[2*k+1])
            : 1'b0;
   end

   // State register; triggers while running leave the state unchanged
   osptmr_state_t state_next;
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         OSPTMR_WAIT:
            if (start)
               state_next = OSPTMR_RUN;
         OSPTMR_RUN:
            if (!run_bit || !active_mode || stop_now)
               state_next = OSPTMR_WAIT;
         default:
            state_next = OSPTMR_WAIT;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= OSPTMR_WAIT;
         cnt_reg <= osptmr_pkg::CNT_PARK;
         pre_reg <= 7'h00;
         act_reg <= 4'h0;
         trig_d_reg <= 1'b0;
         evt_d_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pre_reg <= running ? pre_next : 7'h00;
         act_reg <= act_next;
         trig_d_reg <= trig_lvl;
         evt_d_reg <= evt_lvl;
      end
   end

   // Outputs registered
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         tmr_out <= '0;
      else
      begin
         tmr_out.pin <= pin_next;
         tmr_out.period_irq <= per_irq_now;
         tmr_out.chan_irq <= ch_irq;
      end
   end

   // Register writes at the access phase; capture and option regs are
   // stored for readback but steer nothing
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl0_reg <= osptmr_pkg::CTL0_RST;
         ctl1_reg <= osptmr_pkg::CTL1_RST;
         ioc0_reg <= osptmr_pkg::IOC0_RST;
         ioc1_reg <= 8'h00;
         ioc2_reg <= osptmr_pkg::IOC2_RST;
         opt0_reg <= 8'h00;
         for (int m = 0; m < 4; m++)
            ccr_reg[m] <= osptmr_pkg::CCR_RST;
      end
      else if (acc_wr)
      begin
         if (hit_ctl0)
            ctl0_reg <= pwdata[7:0];
         if (hit_ctl1)
            ctl1_reg <= {1'b0, 1'b0, pwdata[5:0]}; // trigger bit self-clears
         if (hit_ioc0)
            ioc0_reg <= pwdata[7:0];
         if (hit_ioc1)
            ioc1_reg <= pwdata[7:0];
         if (hit_ioc2)
            ioc2_reg <= {4'h0, pwdata[3:0]};
         if (hit_opt0)
            opt0_reg <= pwdata[7:0];
         for (int m = 0; m < 4; m++)
            if (hit_ccr[m])
               ccr_reg[m] <= pwdata[15:0];
      end
   end

   // Read mux
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_ctl0)
         rd_mux = {24'h0, ctl0_reg};
      if (hit_ctl1)
         rd_mux = {24'h0, ctl1_reg};
      if (hit_ioc0)
         rd_mux = {24'h0, ioc0_reg};
      if (hit_ioc1)
         rd_mux = {24'h0, ioc1_reg};
      if (hit_ioc2)
         rd_mux = {24'h0, ioc2_reg};
      if (hit_opt0)
         rd_mux = {24'h0, opt0_reg};
      if (hit_cnt)
         rd_mux = {16'h0, cnt_reg};
      if (hit_stat)
         rd_mux = {30'h0, running, !running};
      for (int m = 0; m < 4; m++)
         if (hit_ccr[m])
            rd_mux = {16'h0, ccr_reg[m]};
   end

   // No wait state: answer ready in the access phase's first cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   AST_START_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
      start |=> cnt_reg == 16'h0000 && state_reg == OSPTMR_RUN)
      else $error("start did not clear counter");
   AST_STOP_PARK: assert property (@(posedge clock) disable iff (!rst_n)
      stop_now && run_bit |=> cnt_reg == 16'hFFFF
      && state_reg == OSPTMR_WAIT)
      else $error("counter did not park");
   AST_IGNORE_TRIG: assert property (@(posedge clock) disable iff (!rst_n)
      running && one_shot && trig && run_bit && !stop_now
      |=> state_reg == OSPTMR_RUN
      && cnt_reg == ($past(cnt_tick) ? $past(cnt_inc)
      : $past(cnt_reg)))
      else $error("trigger disturbed running pulse");
   AST_WAIT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      !running && !trig |=> cnt_reg == 16'hFFFF)
      else $error("counter moved while waiting");
   AST_CH_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
      ch_irq[0] |=> tmr_out.chan_irq[0]
      && act_reg[1])
      else $error("channel irq not with assert");
   AST_PER_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
      tick_run && cnt_match0 && !ext_retrig
      |=> tmr_out.period_irq
      && (!$past(one_shot) || state_reg == OSPTMR_WAIT))
      else $error("period irq missing");
   AST_SUPPRESS: assert property (@(posedge clock) disable iff (!rst_n)
      ext_retrig |=> !tmr_out.period_irq && cnt_reg == 16'h0000)
      else $error("retrigger not handled");
   AST_CH0_RUN: assert property (@(posedge clock) disable iff (!rst_n)
      ioc0_reg[0] && running && run_bit && !stop_now
      |=> tmr_out.pin[0])
      else $error("channel 0 not active while running");
endmodule : osptmr_top

// *** inc/osptmr_pkg.sv ***
/*
 One-shot pulse timer package: register offsets, field positions,
 reset values, mode codes and bundled output types.
 Assumes a 32-bit APB slave with word-aligned registers.
*/
package osptmr_pkg;
   localparam logic [7:0] CTL0_OFF = 8'h00;
   localparam logic [7:0] CTL1_OFF = 8'h04;
   localparam logic [7:0] IOC0_OFF = 8'h08;
   localparam logic [7:0] IOC1_OFF = 8'h0C;
   localparam logic [7:0] IOC2_OFF = 8'h10;
   localparam logic [7:0] OPT0_OFF = 8'h14;
   localparam logic [7:0] CCR0_OFF = 8'h18;
   localparam logic [7:0] CCR1_OFF = 8'h1C;
   localparam logic [7:0] CCR2_OFF = 8'h20;
   localparam logic [7:0] CCR3_OFF = 8'h24;
   localparam logic [7:0] CNT_OFF = 8'h28;
   localparam logic [7:0] STAT_OFF = 8'h2C;
   localparam int CTL0_RUN_POS = 7;
   localparam int CTL1_SWTRG_POS = 6;
   localparam int CTL1_MD_LSB = 0;
   localparam logic [2:0] MODE_ONESHOT = 3'h3;
   localparam logic [2:0] MODE_EXTTRIG = 3'h2;
   localparam logic [15:0] CNT_PARK = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [7:0] CTL0_RST = 8'h00;
   localparam logic [7:0] CTL1_RST = 8'h00;
   localparam logic [7:0] IOC0_RST = 8'h00;
   localparam logic [7:0] IOC2_RST = 8'h00;
   localparam logic [15:0] CCR_RST = 16'h0000;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic [3:0] pin;
      logic period_irq;
      logic [2:0] chan_irq;
   } osptmr_out_t;
endpackage : osptmr_pkg

// *** verilog/osptmr_sync.sv ***
/*
 Three-flop synchroniser with agreement filter for one pin.
 Assumes the pin is asynchronous to clock.
*/
`timescale 1ns/1ps
module osptmr_sync
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pin,
   output logic level
);
   logic [2:0] sh_reg;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         sh_reg <= 3'h0;
      else
         sh_reg <= {sh_reg[1:0], pin};
   end

   // First stage is only read by the second
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         level <= 1'b0;
      else if (sh_reg[1] == sh_reg[2])
         level <= sh_reg[2];
   end
endmodule : osptmr_sync

// *** tb/osptmr_partner.sv ***
/*
 Trigger source and pulse output loads on the board side of the timer.
 Assumes the bench pulses fire for one clock to request a trigger edge.
*/
`timescale 1ns/1ps
module osptmr_partner
#(
   parameter int HOLD = 6
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic [3:0] pins,
   output logic trigger_pin
);
   int hold_cnt;
   // Held high several clocks so the three-flop filter sees it
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_cnt <= 0;
         trigger_pin <= 1'b0;
      end
      else
      begin
         hold_cnt <= fire ? HOLD : (hold_cnt > 0 ? hold_cnt - 1 : 0);
         trigger_pin <= fire || hold_cnt > 1;
      end
   end
endmodule : osptmr_partner

// *** tb/tb_osptmr.sv ***
/*
 Self-checking bench: APB register tasks, software and pin triggers.
 Assumes an APB slave that answers in its own time and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb_osptmr;
   logic clock, rst_n, psel, penable, pwrite, fire, trigger_pin, last_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr;
   logic [3:0] pin_q;
   osptmr_pkg::osptmr_out_t tmr_out;
   int num_errors, tests_run, cyc, t0r, t1r, t1f, t2f, t2r;

   osptmr_top i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_pin(trigger_pin),
      .event_pin(1'b0), .tmr_out(tmr_out));
   osptmr_partner i_partner (.clock(clock), .rst_n(rst_n), .fire(fire),
      .pins(tmr_out.pin), .trigger_pin(trigger_pin));

   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("Errors %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   // Holds the request until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rd

   task automatic wait_period();
      int n;
      n = 0;
      while (tmr_out.period_irq !== 1'b1 && n < 400)
      begin
         @(posedge clock);
         n++;
      end
      check({31'h0, n < 400}, 32'h1);
      repeat (4) @(posedge clock);
   endtask : wait_period

   task automatic pulse_widths(input int sel);
      check(t1f - t1r, 16 << sel);
      check(t2r - t2f, 11 << sel);
      rd(osptmr_pkg::CNT_OFF, 32'hFFFF);
   endtask : pulse_widths

   // Edge monitor; interrupts must line up with the pin changes
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      pin_q <= tmr_out.pin;
      if (tmr_out.pin[0] && !pin_q[0])
      begin
         t0r <= cyc;
         if (tmr_out.pin[2])
            check({31'h0, tmr_out.chan_irq[2]}, 32'h1);
      end
      if (tmr_out.pin[1] && !pin_q[1])
      begin
         t1r <= cyc;
         check({29'h0, tmr_out.chan_irq}, 32'h1);
         check({31'h0, tmr_out.pin[3]}, 32'h0);
      end
      if (!tmr_out.pin[1] && pin_q[1])
      begin
         t1f <= cyc;
         check({31'h0, tmr_out.period_irq}, 32'h1);
      end
      if (!tmr_out.pin[2] && pin_q[2])
      begin
         t2f <= cyc;
         check({29'h0, tmr_out.chan_irq}, 32'h2);
      end
      if (tmr_out.pin[2] && !pin_q[2])
         t2r <= cyc;
   end

   initial
   begin
      #(25 * 20000);
      num_errors++;
      close_out();
   end

   initial
   begin
      {rst_n, psel, penable, pwrite, fire} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      pin_q = 4'h0;
      {num_errors, tests_run, cyc} = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rd(osptmr_pkg::CNT_OFF, 32'hFFFF);
      rd(osptmr_pkg::CTL0_OFF, 32'h0);
      rd(8'h40, 32'h0);
      check({31'h0, last_err}, 32'h1);
      xfer(1'b1, osptmr_pkg::IOC2_OFF, 32'hFF);
      rd(osptmr_pkg::IOC2_OFF, 32'h0F);
      xfer(1'b1, osptmr_pkg::IOC2_OFF, 32'h01);
      xfer(1'b1, osptmr_pkg::IOC0_OFF, 32'h02);
      repeat (3) @(posedge clock);
      check({31'h0, tmr_out.pin[0]}, 32'h1);
      // Garbage in the unused registers must not disturb the pulses
      xfer(1'b1, osptmr_pkg::IOC1_OFF, 32'hFF);
      xfer(1'b1, osptmr_pkg::OPT0_OFF, 32'hFF);
      xfer(1'b1, osptmr_pkg::CCR0_OFF, 32'd20);
      xfer(1'b1, osptmr_pkg::CCR1_OFF, 32'd5);
      xfer(1'b1, osptmr_pkg::CCR2_OFF, 32'd10);
      xfer(1'b1, osptmr_pkg::CCR3_OFF, 32'd0);
      rd(osptmr_pkg::CCR1_OFF, 32'd5);
      xfer(1'b1, osptmr_pkg::IOC0_OFF, 32'h35);
      xfer(1'b1, osptmr_pkg::CTL1_OFF, 32'h03);
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      repeat (20) @(posedge clock);
      rd(osptmr_pkg::CNT_OFF, 32'hFFFF);
      for (int sel = 0; sel < 2; sel++)
      begin
         xfer(1'b1, osptmr_pkg::CTL0_OFF, sel);
         xfer(1'b1, osptmr_pkg::CTL0_OFF, 32'h80 | sel);
         repeat (10) @(posedge clock);
         rd(osptmr_pkg::CNT_OFF, 32'hFFFF);
         xfer(1'b1, osptmr_pkg::CTL1_OFF, 32'h43);
         wait_period();
         pulse_widths(sel);
         if (sel == 0)
         begin
            check(t1r - t0r, 32'd5);
            check(t2f - t0r, 32'd10);
         end
      end
      xfer(1'b1, osptmr_pkg::CTL0_OFF, 32'h0);
      xfer(1'b1, osptmr_pkg::CTL0_OFF, 32'h80);
      @(posedge clock);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      repeat (10) @(posedge clock);
      // A second edge in mid-pulse must leave the widths unchanged
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      xfer(1'b0, osptmr_pkg::CNT_OFF, 32'h0);
      check({31'h0, q <= 32'd20}, 32'h1);
      wait_period();
      pulse_widths(0);
      // Lower the compares only while stopped
      xfer(1'b1, osptmr_pkg::CTL0_OFF, 32'h0);
      xfer(1'b1, osptmr_pkg::CCR0_OFF, 32'd16);
      xfer(1'b1, osptmr_pkg::CCR1_OFF, 32'd3);
      xfer(1'b1, osptmr_pkg::CTL0_OFF, 32'h80);
      xfer(1'b1, osptmr_pkg::CTL1_OFF, 32'h43);
      wait_period();
      check(t1r - t0r, 32'd3);
      check(t1f - t1r, 32'd14);
      check(t2r - t2f, 32'd7);
      // External mode: a trigger after the period irq restarts the count
      xfer(1'b1, osptmr_pkg::CTL1_OFF, 32'h42);
      wait_period();
      xfer(1'b1, osptmr_pkg::CTL1_OFF, 32'h42);
      xfer(1'b0, osptmr_pkg::CNT_OFF, 32'h0);
      check({31'h0, q < 32'd5}, 32'h1);
      close_out();
   end
endmodule : tb_osptmr
